// ==== system_config_pin_priority.sv ====
// system configuration registers and port a shared-pin ownership
// assumes apb master on pclk; por_n is a level from the power-on detector,
// stop_mode and the function enables come from logic on pclk
//
// Overview of operation
// RQ1 - any reset: all shared pins plain inputs
// RQ2 - pin0: analog0, timer0, keyboard0, port
// RQ3 - pin1: analog1, timer1, keyboard1, port
// RQ4 - pin2: interrupt, keyboard2, timer clock, port
// RQ5 - pin3: reset, keyboard3, port
// RQ6 - pin4: osc output, analog2, keyboard4, port
// RQ7 - pin5: osc input, analog3, keyboard5, port
// RQ8 - pullup bit one disconnects interrupt pullup
// RQ9 - interrupt select bit activates interrupt function
// RQ10 - decode two-bit oscillator option field
// RQ11 - reset select bit activates reset function
// RQ12 - reset select cleared only by power-on
// RQ13 - watchdog period 8176 or 262128 cycles
// RQ14 - stop wakeup period 512 or 16384 cycles
// RQ15 - monitor stop enable; any reset clears it
// RQ16 - reset disable bit blocks monitor resets
// RQ17 - first write per register only after reset
`timescale 1ns/1ps
module system_config_pin_priority
    import sysconfig_pkg::*;
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      por_n,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [sysconfig_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      stop_mode,
    input  wire logic [3:0]                analog_channel_en,
    input  wire logic [1:0]                timer_channel_en,
    input  wire logic                      timer_external_clock_en,
    input  wire logic [5:0]                keyboard_input_en,
    input  wire logic                      oscillator_output_en,
    input  wire logic                      voltage_monitor_trip,
    output logic                           interrupt_pullup_connect,
    output logic                           interrupt_function_active,
    output logic                           reset_function_active,
    output sysconfig_pkg::osc_sel_t        oscillator_select,
    output logic      [17:0]               watchdog_timeout_cycles,
    output logic      [17:0]               wakeup_period_cycles,
    output logic                           voltage_monitor_enable,
    output logic                           voltage_monitor_reset,
    output sysconfig_pkg::pin_owner_t      port_a_bit_zero_owner,
    output sysconfig_pkg::pin_owner_t      port_a_bit_one_owner,
    output sysconfig_pkg::pin_owner_t      port_a_bit_two_owner,
    output sysconfig_pkg::pin_owner_t      port_a_bit_three_owner,
    output sysconfig_pkg::pin_owner_t      port_a_bit_four_owner,
    output sysconfig_pkg::pin_owner_t      port_a_bit_five_owner
);
    import sysconfig_pkg::*;

    // ------------------------------------------------------------
    // power-on reset synchroniser
    // ------------------------------------------------------------
    logic       por_meta_reg;
    logic       por_sync_reg;

    // no warm reset here, so a warm reset never looks like a power-on
    always_ff @(posedge pclk) begin
        por_meta_reg <= por_n;
        por_sync_reg <= por_meta_reg;
    end

    // power-on flag: set while the synchronised power-on level is low
    wire        por_active = !por_sync_reg;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire        access     = psel && penable;
    wire        hit_two    = (paddr == CFG_TWO_ADDR);
    wire        hit_one    = (paddr == CFG_ONE_ADDR);
    wire        wr_two     = access && pwrite && hit_two && pstrb[0];
    wire        wr_one     = access && pwrite && hit_one && pstrb[0];

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [7:0] cfg_two_reg;
    logic [7:0] cfg_one_reg;
    logic       two_locked_reg;
    logic       one_locked_reg;
    logic       rst_sel_reg;
    logic       trip_reg;
    logic       soft_reset_reg;

    wire  [7:0] cfg_two_next = pwdata[7:0] & CFG_TWO_WMASK;
    wire  [7:0] cfg_one_next = pwdata[7:0];

    // soft_reset_reg is set while presetn is low and for the first cycle after its release; power-on alone does not set it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_reset_reg <= 1'b1;
        end else begin
            soft_reset_reg <= 1'b0;
        end
    end

    // reset-held fields; the power-on and trip bits live separately
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_two_reg    <= CFG_RESET;
            cfg_one_reg    <= CFG_RESET;                            // RQ15
            two_locked_reg <= 1'b0;
            one_locked_reg <= 1'b0;
        end else begin
            if (wr_two && !two_locked_reg) begin                   // RQ17
                cfg_two_reg    <= cfg_two_next;
                two_locked_reg <= 1'b1;
            end
            if (wr_one && !one_locked_reg) begin                   // RQ17
                cfg_one_reg    <= cfg_one_next & ~CFG_ONE_WARM_KEEP;
                one_locked_reg <= 1'b1;
            end
        end
    end

    // reset select and trip bit survive warm resets; cleared by power-on
    always_ff @(posedge pclk) begin
        if (por_active) begin
            rst_sel_reg <= 1'b0;                                    // RQ12
            trip_reg    <= 1'b0;
        end else if (wr_two && !two_locked_reg) begin
            rst_sel_reg <= pwdata[RESET_FUNC_SEL_BIT];              // RQ12
        end else if (wr_one && !one_locked_reg) begin
            trip_reg    <= pwdata[VMON_TRIP_BIT];
        end
    end

    wire  [7:0] two_view = {cfg_two_reg[7:1], rst_sel_reg};
    wire  [7:0] one_view = {cfg_one_reg[7:4], trip_reg,
                            cfg_one_reg[2:0]};

    // ------------------------------------------------------------
    // apb answer: zero wait states, unmapped reads zero with error
    // ------------------------------------------------------------
    wire        unmapped = !(hit_two || hit_one);
    wire [31:0] rd_mux   = hit_two ? {24'h000000, two_view} :
                           hit_one ? {24'h000000, one_view} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = access && unmapped;

    // ------------------------------------------------------------
    // decoded configuration
    // ------------------------------------------------------------
    wire        irq_sel  = two_view[IRQ_FUNC_SEL_BIT];
    wire        rst_sel  = two_view[RESET_FUNC_SEL_BIT];
    wire        wd_short = one_view[WDOG_PERIOD_BIT];
    wire        vm_off   = one_view[VMON_PWR_DOWN_BIT];

    assign interrupt_pullup_connect  = !two_view[IRQ_PULLUP_DIS_BIT];      // RQ8
    assign interrupt_function_active = irq_sel;                            // RQ9
    assign reset_function_active     = rst_sel;                            // RQ11
    assign oscillator_select = osc_sel_t'({two_view[OSC_OPT_HI_BIT],
                                           two_view[OSC_OPT_LO_BIT]});    // RQ10
    assign watchdog_timeout_cycles = wd_short ? WDOG_SHORT_CYCLES
                                              : WDOG_LONG_CYCLES;          // RQ13
    assign wakeup_period_cycles    = wd_short ? WAKE_SHORT_CYCLES
                                              : WAKE_LONG_CYCLES;          // RQ14
    assign voltage_monitor_enable  = !vm_off &&
                                     (!stop_mode || one_view[VMON_STOP_EN_BIT]); // RQ15
    assign voltage_monitor_reset   = voltage_monitor_enable && voltage_monitor_trip &&
                                     !one_view[VMON_RST_DIS_BIT];          // RQ16

    // ------------------------------------------------------------
    // pin ownership; the oscillator pins follow the option field
    // ------------------------------------------------------------
    wire        osc_in_used  = (oscillator_select != OSC_INTERNAL);
    wire        osc_out_used = (oscillator_select == OSC_EXT_CRYSTAL) ||
                               ((oscillator_select == OSC_EXT_RC) && oscillator_output_en);
    wire        in_reset     = soft_reset_reg || por_active;

    assign port_a_bit_zero_owner  = in_reset                ? OWN_PORT :   // RQ1
                                    analog_channel_en[0]    ? OWN_ANALOG : // RQ2
                                    timer_channel_en[0]     ? OWN_TIMER :
                                    keyboard_input_en[0]    ? OWN_KEYBOARD : OWN_PORT;
    assign port_a_bit_one_owner   = in_reset                ? OWN_PORT :   // RQ1
                                    analog_channel_en[1]    ? OWN_ANALOG : // RQ3
                                    timer_channel_en[1]     ? OWN_TIMER :
                                    keyboard_input_en[1]    ? OWN_KEYBOARD : OWN_PORT;
    assign port_a_bit_two_owner   = in_reset                ? OWN_PORT :   // RQ1
                                    irq_sel                 ? OWN_INTERRUPT : // RQ4
                                    keyboard_input_en[2]    ? OWN_KEYBOARD :
                                    timer_external_clock_en ? OWN_TIMER_CLOCK : OWN_PORT;
    assign port_a_bit_three_owner = in_reset                ? OWN_PORT :   // RQ1
                                    rst_sel                 ? OWN_RESET :  // RQ5
                                    keyboard_input_en[3]    ? OWN_KEYBOARD : OWN_PORT;
    assign port_a_bit_four_owner  = in_reset                ? OWN_PORT :   // RQ1
                                    osc_out_used            ? OWN_OSCILLATOR : // RQ6
                                    analog_channel_en[2]    ? OWN_ANALOG :
                                    keyboard_input_en[4]    ? OWN_KEYBOARD : OWN_PORT;
    assign port_a_bit_five_owner  = in_reset                ? OWN_PORT :   // RQ1
                                    osc_in_used             ? OWN_OSCILLATOR : // RQ7
                                    analog_channel_en[3]    ? OWN_ANALOG :
                                    keyboard_input_en[5]    ? OWN_KEYBOARD : OWN_PORT;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_first_write_two;
        wr_two && !two_locked_reg;
    endsequence

    property p_reset_ports;
        @(posedge pclk) $rose(presetn) |-> port_a_bit_two_owner == OWN_PORT &&
            port_a_bit_three_owner == OWN_PORT;
    endproperty
    a_reset_ports: assert property (p_reset_ports) else $error("pin not port after reset"); // RQ1

    property p_pin0;
        @(posedge pclk) disable iff (!presetn)
        !in_reset && analog_channel_en[0] |-> port_a_bit_zero_owner == OWN_ANALOG;
    endproperty
    a_pin0: assert property (p_pin0) else $error("pin0 analog not first"); // RQ2

    property p_pin1;
        @(posedge pclk) disable iff (!presetn)
        !in_reset && !analog_channel_en[1] && timer_channel_en[1]
            |-> port_a_bit_one_owner == OWN_TIMER;
    endproperty
    a_pin1: assert property (p_pin1) else $error("pin1 timer order wrong"); // RQ3

    property p_pin2;
        @(posedge pclk) disable iff (!presetn)
        !in_reset && !irq_sel && keyboard_input_en[2]
            |-> port_a_bit_two_owner == OWN_KEYBOARD;
    endproperty
    a_pin2: assert property (p_pin2) else $error("pin2 keyboard order wrong"); // RQ4

    property p_pin3;
        @(posedge pclk) disable iff (!presetn)
        !in_reset && rst_sel |-> port_a_bit_three_owner == OWN_RESET;
    endproperty
    a_pin3: assert property (p_pin3) else $error("pin3 reset not first"); // RQ5

    property p_lock_two;
        @(posedge pclk) disable iff (!presetn)
        s_first_write_two |=> two_locked_reg && cfg_two_reg == $past(cfg_two_next);
    endproperty
    a_lock_two: assert property (p_lock_two) else $error("first write not stored"); // RQ17

    property p_locked_hold;
        @(posedge pclk) disable iff (!presetn)
        two_locked_reg |=> $stable(cfg_two_reg);
    endproperty
    a_locked_hold: assert property (p_locked_hold) else $error("locked register changed"); // RQ17

    property p_wdog;
        @(posedge pclk) disable iff (!presetn)
        wd_short |-> watchdog_timeout_cycles == WDOG_SHORT_CYCLES &&
            wakeup_period_cycles == WAKE_SHORT_CYCLES;
    endproperty
    a_wdog: assert property (p_wdog) else $error("short periods wrong"); // RQ13

    property p_vmon_reset;
        @(posedge pclk) disable iff (!presetn)
        one_view[VMON_RST_DIS_BIT] |-> !voltage_monitor_reset;
    endproperty
    a_vmon_reset: assert property (p_vmon_reset) else $error("monitor reset not blocked"); // RQ16

    property p_por_clear;
        @(posedge pclk) por_active |=> !rst_sel_reg;
    endproperty
    a_por_clear: assert property (p_por_clear) else $error("reset select survived power-on"); // RQ12

    property p_pin2_irq;
        @(posedge pclk) disable iff (!presetn)
        !in_reset && irq_sel |-> port_a_bit_two_owner == OWN_INTERRUPT;
    endproperty
    a_pin2_irq: assert property (p_pin2_irq) else $error("pin2 interrupt not first"); // RQ4

    property p_pin4;
        @(posedge pclk) disable iff (!presetn)
        !in_reset && osc_out_used |-> port_a_bit_four_owner == OWN_OSCILLATOR;
    endproperty
    a_pin4: assert property (p_pin4) else $error("pin4 oscillator not first"); // RQ6

    property p_pin5;
        @(posedge pclk) disable iff (!presetn)
        !in_reset && osc_in_used |-> port_a_bit_five_owner == OWN_OSCILLATOR;
    endproperty
    a_pin5: assert property (p_pin5) else $error("pin5 oscillator not first"); // RQ7

    property p_pullup;
        @(posedge pclk) disable iff (!presetn)
        s_first_write_two |=> interrupt_pullup_connect != $past(pwdata[IRQ_PULLUP_DIS_BIT]);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pullup bit not applied"); // RQ8

    property p_irq_sel;
        @(posedge pclk) disable iff (!presetn)
        s_first_write_two |=> interrupt_function_active == $past(pwdata[IRQ_FUNC_SEL_BIT]);
    endproperty
    a_irq_sel: assert property (p_irq_sel) else $error("interrupt select not applied"); // RQ9

    property p_osc;
        @(posedge pclk) disable iff (!presetn)
        s_first_write_two
            |=> oscillator_select == osc_sel_t'($past(pwdata[OSC_OPT_HI_BIT:OSC_OPT_LO_BIT]));
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator option wrong"); // RQ10

    property p_rst_sel;
        @(posedge pclk) disable iff (!presetn)
        !por_active ##0 s_first_write_two
            |=> reset_function_active == $past(pwdata[RESET_FUNC_SEL_BIT]);
    endproperty
    a_rst_sel: assert property (p_rst_sel) else $error("reset select not applied"); // RQ11

    property p_warm_hold;
        @(posedge pclk) !presetn && !por_active && !psel |=> $stable(rst_sel_reg);
    endproperty
    a_warm_hold: assert property (p_warm_hold) else $error("warm reset changed select"); // RQ12

    property p_long;
        @(posedge pclk) disable iff (!presetn)
        !wd_short |-> watchdog_timeout_cycles == WDOG_LONG_CYCLES &&
            wakeup_period_cycles == WAKE_LONG_CYCLES;
    endproperty
    a_long: assert property (p_long) else $error("long periods wrong"); // RQ14

    property p_vmon_stop;
        @(posedge pclk) disable iff (!presetn)
        stop_mode && !one_view[VMON_STOP_EN_BIT] |-> !voltage_monitor_enable;
    endproperty
    a_vmon_stop: assert property (p_vmon_stop) else $error("monitor on in stop"); // RQ15
endmodule : system_config_pin_priority

// ==== sysconfig_pkg.sv ====
// constants, field layout and types for the system configuration block
// assumes a 32-bit apb slave with word-aligned registers
package sysconfig_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0]  CFG_TWO_INDEX      = 8'h1E;
    localparam logic [7:0]  CFG_ONE_INDEX      = 8'h1F;
    localparam logic [11:0] CFG_TWO_ADDR       = 12'h078;
    localparam logic [11:0] CFG_ONE_ADDR       = 12'h07C;
    localparam int          ADDR_W             = 12;
    localparam logic [7:0]  CFG_RESET          = 8'h00;
    // second register fields
    localparam int          IRQ_PULLUP_DIS_BIT = 7;
    localparam int          IRQ_FUNC_SEL_BIT   = 6;
    localparam int          OSC_OPT_HI_BIT     = 4;
    localparam int          OSC_OPT_LO_BIT     = 3;
    localparam int          RESET_FUNC_SEL_BIT = 0;
    localparam logic [7:0]  CFG_TWO_WMASK      = 8'hD9;
    // first register fields
    localparam int          WDOG_PERIOD_BIT    = 7;
    localparam int          VMON_STOP_EN_BIT   = 6;
    localparam int          VMON_RST_DIS_BIT   = 5;
    localparam int          VMON_PWR_DOWN_BIT  = 4;
    localparam int          VMON_TRIP_BIT      = 3;
    // bits of the first register kept through warm resets (the trip bit only)
    localparam logic [7:0]  CFG_ONE_WARM_KEEP  = 8'h08;
    // timeout and wakeup periods in cycles of their own clocks
    localparam logic [17:0] WDOG_SHORT_CYCLES  = 18'h01FF0;
    localparam logic [17:0] WDOG_LONG_CYCLES   = 18'h3FFF0;
    localparam logic [17:0] WAKE_SHORT_CYCLES  = 18'h00200;
    localparam logic [17:0] WAKE_LONG_CYCLES   = 18'h04000;

    typedef enum logic [1:0] {
        OSC_INTERNAL, OSC_EXT_CLOCK, OSC_EXT_RC, OSC_EXT_CRYSTAL
    } osc_sel_t;

    typedef enum logic [2:0] {
        OWN_PORT, OWN_KEYBOARD, OWN_TIMER, OWN_ANALOG,
        OWN_INTERRUPT, OWN_RESET, OWN_OSCILLATOR, OWN_TIMER_CLOCK
    } pin_owner_t;
endpackage : sysconfig_pkg

// ==== system_config_pin_priority_tb.sv ====
// self-checking testbench for the configuration registers and shared-pin ownership
// assumes sysconfig_pkg is compiled first; the bench drives apb and the function enables
`timescale 1ns/1ps
module system_config_pin_priority_tb;
    import sysconfig_pkg::*;
    logic        pclk, presetn, por_n, psel, penable, pwrite, stop_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb, analog_channel_en;
    logic [1:0]  timer_channel_en;
    logic [5:0]  keyboard_input_en;
    logic        timer_external_clock_en, oscillator_output_en, voltage_monitor_trip;
    logic        pready, pslverr, interrupt_pullup_connect, interrupt_function_active;
    logic        reset_function_active, voltage_monitor_enable, voltage_monitor_reset;
    osc_sel_t    oscillator_select;
    logic [17:0] watchdog_timeout_cycles, wakeup_period_cycles;
    pin_owner_t  own [6];
    int          n_fail, cmp_count;

    system_config_pin_priority DUT (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_mode(stop_mode),
        .analog_channel_en(analog_channel_en), .timer_channel_en(timer_channel_en),
        .timer_external_clock_en(timer_external_clock_en),
        .keyboard_input_en(keyboard_input_en), .oscillator_output_en(oscillator_output_en),
        .voltage_monitor_trip(voltage_monitor_trip),
        .interrupt_pullup_connect(interrupt_pullup_connect),
        .interrupt_function_active(interrupt_function_active),
        .reset_function_active(reset_function_active), .oscillator_select(oscillator_select),
        .watchdog_timeout_cycles(watchdog_timeout_cycles),
        .wakeup_period_cycles(wakeup_period_cycles),
        .voltage_monitor_enable(voltage_monitor_enable),
        .voltage_monitor_reset(voltage_monitor_reset),
        .port_a_bit_zero_owner(own[0]), .port_a_bit_one_owner(own[1]),
        .port_a_bit_two_owner(own[2]), .port_a_bit_three_owner(own[3]),
        .port_a_bit_four_owner(own[4]), .port_a_bit_five_owner(own[5]));

    // ----------------------------------------
    // clock, checking and verdict
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        if (n_fail == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // apb master, reset and stimulus helpers
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       output logic [7:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic       e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [7:0] exp,
                          input logic err_exp);
        logic [7:0] r;
        logic       e;
        apb(1'b0, a, 8'h00, r, e);
        check(nm, r, exp);
        check("pslverr", e, err_exp);
    endtask : rd_chk

    // power selects a power-on reset as well; owners are checked while reset is held
    task automatic do_reset(input logic power);
        @(posedge pclk);
        presetn <= 1'b0;
        por_n   <= ~power;
        repeat (5) @(posedge pclk);
        @(negedge pclk);
        for (int i = 0; i < 6; i++) check("reset_owner", own[i], OWN_PORT);
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        por_n <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask : do_reset

    task automatic set_en(input logic [3:0] ad, input logic [1:0] tc, input logic tk,
                          input logic [5:0] kb);
        @(posedge pclk);
        analog_channel_en       <= ad;
        timer_channel_en        <= tc;
        timer_external_clock_en <= tk;
        keyboard_input_en       <= kb;
        @(negedge pclk);
    endtask : set_en

    task automatic prio_step(input logic [3:0] ad, input logic [1:0] tc, input logic tk,
                             input logic [5:0] kb, input pin_owner_t e [6]);
        set_en(ad, tc, tk, kb);
        for (int i = 0; i < 6; i++) check("owner", own[i], e[i]);
    endtask : prio_step

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_cfg_two();
        set_en(4'hF, 2'b11, 1'b1, 6'h3F);
        rd_chk("cfg_two_rst", CFG_TWO_ADDR, 8'h00, 1'b0);
        rd_chk("cfg_one_rst", CFG_ONE_ADDR, 8'h00, 1'b0);
        rd_chk("unmapped", 12'h080, 8'h00, 1'b1);
        wr(CFG_TWO_ADDR, 8'hFF);
        wr(CFG_TWO_ADDR, 8'h00);
        rd_chk("cfg_two", CFG_TWO_ADDR, 8'hD9, 1'b0);
        @(negedge pclk);
        check("pullup", interrupt_pullup_connect, 1'b0);
        check("irq_func", interrupt_function_active, 1'b1);
        check("rst_func", reset_function_active, 1'b1);
        check("osc_sel", oscillator_select, OSC_EXT_CRYSTAL);
        check("owner2", own[2], OWN_INTERRUPT);
        check("owner3", own[3], OWN_RESET);
        check("owner4", own[4], OWN_OSCILLATOR);
        check("owner5", own[5], OWN_OSCILLATOR);
        do_reset(1'b0);
        rd_chk("cfg_two_warm", CFG_TWO_ADDR, 8'h01, 1'b0);
        @(negedge pclk);
        check("rst_func_warm", reset_function_active, 1'b1);
        check("pullup_warm", interrupt_pullup_connect, 1'b1);
        check("irq_func_warm", interrupt_function_active, 1'b0);
    endtask : s_cfg_two

    // options run downwards so the block ends on the internal oscillator
    task automatic s_osc();
        for (int o = 3; o >= 0; o--) begin
            do_reset(1'b0);
            wr(CFG_TWO_ADDR, {3'b000, 2'(o), 3'b000});
            @(negedge pclk);
            check("osc_sel", oscillator_select, osc_sel_t'(o));
            check("owner5", own[5], (o == 0) ? OWN_ANALOG : OWN_OSCILLATOR);
            check("owner4", own[4], (o >= 2) ? OWN_OSCILLATOR : OWN_ANALOG);
            check("owner3", own[3], OWN_KEYBOARD);
            check("owner2", own[2], OWN_KEYBOARD);
            if (o == 2) begin
                @(posedge pclk);
                oscillator_output_en <= 1'b0;
                @(negedge pclk);
                check("owner4_rc", own[4], OWN_ANALOG);
            end
        end
    endtask : s_osc

    task automatic s_priority();
        prio_step(4'hF, 2'b11, 1'b1, 6'h3F, '{OWN_ANALOG, OWN_ANALOG, OWN_KEYBOARD,
                  OWN_KEYBOARD, OWN_ANALOG, OWN_ANALOG});
        prio_step(4'h0, 2'b11, 1'b1, 6'h3F, '{OWN_TIMER, OWN_TIMER, OWN_KEYBOARD,
                  OWN_KEYBOARD, OWN_KEYBOARD, OWN_KEYBOARD});
        prio_step(4'h0, 2'b00, 1'b1, 6'h3F, '{OWN_KEYBOARD, OWN_KEYBOARD, OWN_KEYBOARD,
                  OWN_KEYBOARD, OWN_KEYBOARD, OWN_KEYBOARD});
        prio_step(4'h0, 2'b00, 1'b1, 6'h00, '{OWN_PORT, OWN_PORT, OWN_TIMER_CLOCK,
                  OWN_PORT, OWN_PORT, OWN_PORT});
        prio_step(4'h5, 2'b10, 1'b0, 6'h00, '{OWN_ANALOG, OWN_TIMER, OWN_PORT,
                  OWN_PORT, OWN_ANALOG, OWN_PORT});
    endtask : s_priority

    task automatic s_cfg_one();
        @(posedge pclk);
        voltage_monitor_trip <= 1'b1;
        wr(CFG_ONE_ADDR, 8'hE8);
        @(negedge pclk);
        check("wdog_short", watchdog_timeout_cycles, WDOG_SHORT_CYCLES);
        check("wake_short", wakeup_period_cycles, WAKE_SHORT_CYCLES);
        check("vmon_rst_blk", voltage_monitor_reset, 1'b0);
        @(posedge pclk);
        stop_mode <= 1'b1;
        @(negedge pclk);
        check("vmon_stop_on", voltage_monitor_enable, 1'b1);
        do_reset(1'b0);
        @(negedge pclk);
        check("vmon_stop_off", voltage_monitor_enable, 1'b0);
        check("wdog_long", watchdog_timeout_cycles, WDOG_LONG_CYCLES);
        check("wake_long", wakeup_period_cycles, WAKE_LONG_CYCLES);
        @(posedge pclk);
        stop_mode <= 1'b0;
        @(negedge pclk);
        check("vmon_rst_on", voltage_monitor_reset, 1'b1);
        rd_chk("cfg_one_warm", CFG_ONE_ADDR, 8'h08, 1'b0);
        wr(CFG_ONE_ADDR, 8'h10);
        @(negedge pclk);
        check("vmon_pwrd", voltage_monitor_enable, 1'b0);
        rd_chk("cfg_one", CFG_ONE_ADDR, 8'h10, 1'b0);
        wr(CFG_TWO_ADDR, 8'h01);
        do_reset(1'b1);
        rd_chk("cfg_two_por", CFG_TWO_ADDR, 8'h00, 1'b0);
    endtask : s_cfg_one

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        {presetn, por_n, psel, penable, pwrite, stop_mode} = 6'h00;
        {paddr, pwdata, pstrb} = {12'h000, 32'h00000000, 4'h1};
        {analog_channel_en, timer_channel_en, keyboard_input_en} = 12'h000;
        {timer_external_clock_en, oscillator_output_en, voltage_monitor_trip} = 3'b010;
        n_fail = 0;
        cmp_count = 0;
        do_reset(1'b1);
        s_cfg_two();
        s_osc();
        s_priority();
        s_cfg_one();
        give_verdict();
    end

    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        give_verdict();
    end
endmodule : system_config_pin_priority_tb
